// >>> logic/slcr_defs.svh
// register map, field positions, reset values and pattern constants of the link control bank
// assumes inclusion by the bank and its serial port, by bare name
`ifndef SLCR_DEFS_SVH
`define SLCR_DEFS_SVH

// serial port framing
`define SLCR_ADDR_W 13
`define SLCR_INSTR_BITS 5'h10
`define SLCR_FRAME_BITS 5'h18
`define SLCR_RD_BIT 15
`define SLCR_RD_ADDR_HI 12
`define SLCR_RD_ADDR_LO 0
`define SLCR_WR_ADDR_HI 20
`define SLCR_WR_ADDR_LO 8

// register offsets
`define SLCR_ADDR_PLL 13'h0021
`define SLCR_ADDR_SIG_LO 13'h0024
`define SLCR_ADDR_SIG_HI 13'h0025
`define SLCR_ADDR_SYNC 13'h003A
`define SLCR_ADDR_LC1 13'h0060
`define SLCR_ADDR_LC2 13'h0061
`define SLCR_ADDR_LC3 13'h0062
`define SLCR_ADDR_LC4 13'h0063

// writable bits; open bits read as zero
`define SLCR_MASK_PLL 8'h08
`define SLCR_MASK_SYNC 8'h07
`define SLCR_MASK_LC1 8'h7F
`define SLCR_MASK_LC2 8'hF7
`define SLCR_MASK_LC3 8'hB7
`define SLCR_MASK_LC4 8'hFF

// reset values
`define SLCR_RST_PLL 8'h00
`define SLCR_RST_SYNC 8'h00
`define SLCR_RST_LC1 8'h00
`define SLCR_RST_LC2 8'h00
`define SLCR_RST_LC3 8'h00
`define SLCR_RST_LC4 8'h00

// field positions
`define SLCR_PLL_LOW_RATE_BIT 3
`define SLCR_SYNC_NEXT_ONLY_BIT 2
`define SLCR_SYNC_DIV_EN_BIT 1
`define SLCR_SYNC_MASTER_BUF_BIT 0
`define SLCR_LC1_TAIL_BIT 6
`define SLCR_LC1_SYNCEN_BIT 4
`define SLCR_LC1_ALIGN_HI 3
`define SLCR_LC1_ALIGN_LO 2
`define SLCR_LC1_CHAR_DIS_BIT 1
`define SLCR_LC1_PDWN_BIT 0
`define SLCR_LC1_SAMPLE_EN_BIT 5
`define SLCR_LC2_SYNCMODE_HI 7
`define SLCR_LC2_SYNCMODE_LO 6
`define SLCR_LC2_SYNC_INV_BIT 5
`define SLCR_LC2_SYNC_CMOS_BIT 4
`define SLCR_LC2_BYPASS_BIT 2
`define SLCR_LC2_INVERT_BIT 1
`define SLCR_LC2_MIRROR_BIT 0
`define SLCR_LC3_CHK_DIS_BIT 7
`define SLCR_LC3_INJ_HI 5
`define SLCR_LC3_INJ_LO 4
`define SLCR_LC3_TPG_HI 2
`define SLCR_LC3_TPG_LO 0

// pattern words and generator seeds
`define SLCR_CHECKER_A 16'h5555
`define SLCR_CHECKER_B 16'hAAAA
`define SLCR_ONES 16'hFFFF
`define SLCR_ZEROS 16'h0000
`define SLCR_PN_LONG_SEED 23'h7FFFFF
`define SLCR_PN_SHORT_SEED 9'h1FF
`define SLCR_USER_LAST 2'h3
`define SLCR_INJ_SAMPLE 2'h0
`define SLCR_INJ_ENC_OUT 2'h1
`define SLCR_SYNC_PIN_OFF 2'h3

`endif

// >>> logic/slcr_pkg.sv
// types shared by the link control bank and its serial port
// assumes nothing from slcr_defs.svh; its codes and widths are written out here
package slcr_pkg;

  typedef enum logic [2:0] {
    SLCR_TPG_NORMAL = 3'h0,
    SLCR_TPG_CHECKER = 3'h1,
    SLCR_TPG_TOGGLE = 3'h2,
    SLCR_TPG_PN_LONG = 3'h3,
    SLCR_TPG_PN_SHORT = 3'h4,
    SLCR_TPG_USER_CONT = 3'h5,
    SLCR_TPG_USER_ONCE = 3'h6,
    SLCR_TPG_UNUSED = 3'h7
  } slcr_tpg_e;

  // gray along idle -> instruction -> data
  typedef enum logic [1:0] {
    SLCR_SP_IDLE = 2'h0,
    SLCR_SP_INSTR = 2'h1,
    SLCR_SP_DATA = 2'h3
  } slcr_sp_state_e;

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0] wdata;
    logic we;
  } slcr_reg_req_s;

  typedef struct packed {
    logic pll_low_rate;
    logic div_next_sync_only;
    logic div_sync_en;
    logic master_sync_buf_en;
    logic tail_bit_en;
    logic sample_en;
    logic link_sync_en;
    logic [1:0] align_seq_mode;
    logic align_char_dis;
    logic link_pdwn;
    logic [1:0] sync_mode;
    logic chksum_dis;
    logic [1:0] inject_point;
    logic [7:0] align_repeat;
  } slcr_link_cfg_s;

endpackage

// >>> logic/slcr_spi_port.sv
// 3-wire serial control port slave: 16-bit instruction then one data byte
// assumes pins from outside the sys_clk domain and a register bank on sys_clk
`timescale 1ns/1ps
`include "slcr_defs.svh"

module slcr_spi_port
  import slcr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic spi_sclk,
  input wire logic spi_csb,
  input wire logic spi_sdio_i,
  output logic spi_sdio_o,
  output logic spi_sdio_oe,
  output slcr_reg_req_s reg_req,
  input wire logic [7:0] reg_rdata
);

  logic [2:0] sclk_sync_r;
  logic [1:0] csb_sync_r;
  logic [1:0] sdio_sync_r;
  slcr_sp_state_e state_r, state_nxt;
  logic [4:0] cnt_r;
  logic [23:0] shift_r;
  logic [7:0] out_r;
  logic rd_r;
  logic we_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_sync_r <= 3'h0;
      csb_sync_r <= 2'h3;
      sdio_sync_r <= 2'h0;
    end else begin
      sclk_sync_r <= {sclk_sync_r[1:0], spi_sclk};
      csb_sync_r <= {csb_sync_r[0], spi_csb};
      sdio_sync_r <= {sdio_sync_r[0], spi_sdio_i};
    end
  end

  wire cs_act = !csb_sync_r[1];
  wire sclk_rise = sclk_sync_r[1] && !sclk_sync_r[2];
  wire sclk_fall = !sclk_sync_r[1] && sclk_sync_r[2];
  wire [23:0] shift_in = {shift_r[22:0], sdio_sync_r[1]};
  wire [4:0] cnt_inc = cnt_r + 5'h01;
  wire instr_done = sclk_rise && (cnt_inc == `SLCR_INSTR_BITS);
  wire frame_done = sclk_rise && (cnt_inc == `SLCR_FRAME_BITS);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SLCR_SP_IDLE: if (cs_act) state_nxt = SLCR_SP_INSTR;
      SLCR_SP_INSTR: if (!cs_act) state_nxt = SLCR_SP_IDLE;
        else if (instr_done) state_nxt = SLCR_SP_DATA;
      SLCR_SP_DATA: if (!cs_act || frame_done) state_nxt = SLCR_SP_IDLE;
      default: state_nxt = SLCR_SP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= SLCR_SP_IDLE;
      cnt_r <= 5'h00;
      shift_r <= 24'h000000;
      out_r <= 8'h00;
      rd_r <= 1'b0;
      we_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      we_r <= frame_done && (state_r == SLCR_SP_DATA) && !rd_r && cs_act;
      if (state_r == SLCR_SP_IDLE) begin
        cnt_r <= 5'h00;
        rd_r <= 1'b0;
      end else if (sclk_rise) begin
        cnt_r <= cnt_inc;
        shift_r <= shift_in;
      end
      if (instr_done && (state_r == SLCR_SP_INSTR)) begin
        rd_r <= shift_in[`SLCR_RD_BIT];
      end
      // read byte loaded once the address is known; shifted on falling sclk
      if (state_r == SLCR_SP_DATA && rd_r && cnt_r == `SLCR_INSTR_BITS && !sclk_rise && !sclk_fall) begin
        out_r <= reg_rdata;
      end else if (state_r == SLCR_SP_DATA && sclk_fall && cnt_r > `SLCR_INSTR_BITS) begin
        out_r <= {out_r[6:0], 1'b0};
      end
    end
  end

  // read address is complete after the instruction, write address after the whole frame
  wire [12:0] rd_addr = shift_r[`SLCR_RD_ADDR_HI:`SLCR_RD_ADDR_LO];
  wire [12:0] wr_addr = shift_r[`SLCR_WR_ADDR_HI:`SLCR_WR_ADDR_LO];
  assign reg_req.addr = rd_r ? rd_addr : wr_addr;
  assign reg_req.wdata = shift_r[7:0];
  assign reg_req.we = we_r;
  assign spi_sdio_o = out_r[7];
  assign spi_sdio_oe = (state_r == SLCR_SP_DATA) && rd_r && cs_act;

endmodule // slcr_spi_port

// >>> logic/slcr_top.sv
// link control register bank with test pattern generator and serial output conditioning
// assumes samples, encoder symbols and self-test signature on sys_clk; serial port and sync pins asynchronous
`timescale 1ns/1ps
`include "slcr_defs.svh"

module slcr_top
  import slcr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic spi_sclk,
  input wire logic spi_csb,
  input wire logic spi_sdio_i,
  output logic spi_sdio_o,
  output logic spi_sdio_oe,
  input wire logic [15:0] sample_in,
  input wire logic [9:0] enc_sym_in,
  input wire logic [15:0] selftest_signature,
  input wire logic [63:0] user_pattern_words,
  input wire logic link_sync_lvds_in,
  input wire logic link_sync_cmos_in,
  output logic [15:0] enc_data_out,
  output logic [9:0] ser_sym_out,
  output logic link_sync_request,
  output slcr_link_cfg_s link_cfg
);

  slcr_reg_req_s req;
  logic [7:0] rdata;
  logic [7:0] pll_rate_control_r;
  logic [7:0] divider_sync_control_r;
  logic [7:0] link_control_first_r;
  logic [7:0] link_control_second_r;
  logic [7:0] link_control_third_r;
  logic [7:0] alignment_repeat_count_r;
  logic [1:0] lvds_sync_r;
  logic [1:0] cmos_sync_r;
  logic sync_req_r;
  logic phase_r;
  logic [22:0] pn_long_r;
  logic [8:0] pn_short_r;
  logic [1:0] user_idx_r;
  logic user_done_r;
  slcr_tpg_e mode_prev_r;
  logic [15:0] enc_data_r;
  logic [9:0] ser_sym_r;

  slcr_spi_port u_spi_port (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .spi_sclk(spi_sclk),
    .spi_csb(spi_csb),
    .spi_sdio_i(spi_sdio_i),
    .spi_sdio_o(spi_sdio_o),
    .spi_sdio_oe(spi_sdio_oe),
    .reg_req(req),
    .reg_rdata(rdata)
  );

  // register decode
  wire sel_pll = req.addr == `SLCR_ADDR_PLL;
  wire sel_sig_lo = req.addr == `SLCR_ADDR_SIG_LO;
  wire sel_sig_hi = req.addr == `SLCR_ADDR_SIG_HI;
  wire sel_sync = req.addr == `SLCR_ADDR_SYNC;
  wire sel_lc1 = req.addr == `SLCR_ADDR_LC1;
  wire sel_lc2 = req.addr == `SLCR_ADDR_LC2;
  wire sel_lc3 = req.addr == `SLCR_ADDR_LC3;
  wire sel_lc4 = req.addr == `SLCR_ADDR_LC4;

  assign rdata = sel_pll ? pll_rate_control_r :
                 sel_sig_lo ? selftest_signature[7:0] :
                 sel_sig_hi ? selftest_signature[15:8] :
                 sel_sync ? divider_sync_control_r :
                 sel_lc1 ? link_control_first_r :
                 sel_lc2 ? link_control_second_r :
                 sel_lc3 ? link_control_third_r :
                 sel_lc4 ? alignment_repeat_count_r : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pll_rate_control_r <= `SLCR_RST_PLL;
      divider_sync_control_r <= `SLCR_RST_SYNC;
      link_control_first_r <= `SLCR_RST_LC1;
      link_control_second_r <= `SLCR_RST_LC2;
      link_control_third_r <= `SLCR_RST_LC3;
      alignment_repeat_count_r <= `SLCR_RST_LC4;
    end else if (req.we) begin
      if (sel_pll) pll_rate_control_r <= req.wdata & `SLCR_MASK_PLL;
      if (sel_sync) divider_sync_control_r <= req.wdata & `SLCR_MASK_SYNC;
      if (sel_lc1) link_control_first_r <= req.wdata & `SLCR_MASK_LC1;
      if (sel_lc2) link_control_second_r <= req.wdata & `SLCR_MASK_LC2;
      if (sel_lc3) link_control_third_r <= req.wdata & `SLCR_MASK_LC3;
      if (sel_lc4) alignment_repeat_count_r <= req.wdata & `SLCR_MASK_LC4;
    end
  end

  // configuration fields for the rest of the link
  assign link_cfg.pll_low_rate = pll_rate_control_r[`SLCR_PLL_LOW_RATE_BIT];
  assign link_cfg.div_next_sync_only = divider_sync_control_r[`SLCR_SYNC_NEXT_ONLY_BIT];
  assign link_cfg.div_sync_en = divider_sync_control_r[`SLCR_SYNC_DIV_EN_BIT];
  assign link_cfg.master_sync_buf_en = divider_sync_control_r[`SLCR_SYNC_MASTER_BUF_BIT];
  assign link_cfg.tail_bit_en = link_control_first_r[`SLCR_LC1_TAIL_BIT];
  assign link_cfg.sample_en = link_control_first_r[`SLCR_LC1_SAMPLE_EN_BIT];
  assign link_cfg.link_sync_en = link_control_first_r[`SLCR_LC1_SYNCEN_BIT];
  assign link_cfg.align_seq_mode = link_control_first_r[`SLCR_LC1_ALIGN_HI:`SLCR_LC1_ALIGN_LO];
  assign link_cfg.align_char_dis = link_control_first_r[`SLCR_LC1_CHAR_DIS_BIT];
  assign link_cfg.link_pdwn = link_control_first_r[`SLCR_LC1_PDWN_BIT];
  assign link_cfg.sync_mode = link_control_second_r[`SLCR_LC2_SYNCMODE_HI:`SLCR_LC2_SYNCMODE_LO];
  assign link_cfg.chksum_dis = link_control_third_r[`SLCR_LC3_CHK_DIS_BIT];
  assign link_cfg.inject_point = link_control_third_r[`SLCR_LC3_INJ_HI:`SLCR_LC3_INJ_LO];
  assign link_cfg.align_repeat = alignment_repeat_count_r;

  // sync request input: both buffers synchronised, then one is chosen
  wire sync_cmos = link_control_second_r[`SLCR_LC2_SYNC_CMOS_BIT];
  wire sync_inv = link_control_second_r[`SLCR_LC2_SYNC_INV_BIT];
  wire sync_pin_off = link_cfg.sync_mode == `SLCR_SYNC_PIN_OFF;
  wire sync_raw = sync_cmos ? cmos_sync_r[1] : lvds_sync_r[1];
  wire sync_sel = !sync_pin_off && (sync_raw ^ sync_inv);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lvds_sync_r <= 2'h0;
      cmos_sync_r <= 2'h0;
      sync_req_r <= 1'b0;
    end else begin
      lvds_sync_r <= {lvds_sync_r[0], link_sync_lvds_in};
      cmos_sync_r <= {cmos_sync_r[0], link_sync_cmos_in};
      sync_req_r <= sync_sel;
    end
  end

  assign link_sync_request = sync_req_r;

  // pattern generator
  function automatic logic [22:0] pn_long_adv(input logic [22:0] s);
    logic [22:0] t;
    t = s;
    for (int i = 0; i < 16; i++) begin
      t = {t[21:0], t[22] ^ t[17]};
    end
    return t;
  endfunction

  function automatic logic [8:0] pn_short_adv(input logic [8:0] s);
    logic [8:0] t;
    t = s;
    for (int i = 0; i < 16; i++) begin
      t = {t[7:0], t[8] ^ t[4]};
    end
    return t;
  endfunction

  wire [2:0] mode_bits = link_control_third_r[`SLCR_LC3_TPG_HI:`SLCR_LC3_TPG_LO];
  wire slcr_tpg_e mode = slcr_tpg_e'(mode_bits);
  wire mode_change = mode != mode_prev_r;
  // word0 already in the change cycle, so no stale word leaks out
  wire [1:0] user_sel = mode_change ? 2'h0 : user_idx_r;
  wire [15:0] user_word = user_pattern_words[{user_sel, 4'h0} +: 16];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= 1'b0;
      pn_long_r <= `SLCR_PN_LONG_SEED;
      pn_short_r <= `SLCR_PN_SHORT_SEED;
      user_idx_r <= 2'h0;
      user_done_r <= 1'b0;
      mode_prev_r <= SLCR_TPG_NORMAL;
    end else begin
      mode_prev_r <= mode;
      phase_r <= mode_change ? 1'b0 : !phase_r;
      pn_long_r <= mode_change ? `SLCR_PN_LONG_SEED : pn_long_adv(pn_long_r);
      pn_short_r <= mode_change ? `SLCR_PN_SHORT_SEED : pn_short_adv(pn_short_r);
      if (mode_change) begin
        user_idx_r <= 2'h1;
        user_done_r <= 1'b0;
      end else if (!user_done_r) begin
        user_idx_r <= user_idx_r + 2'h1;
        if (mode == SLCR_TPG_USER_ONCE && user_idx_r == `SLCR_USER_LAST) begin
          user_done_r <= 1'b1;
        end
      end
    end
  end

  logic [15:0] pat_word;
  logic pat_act;

  always_comb begin
    pat_word = sample_in;
    pat_act = 1'b1;
    case (mode)
      SLCR_TPG_NORMAL: pat_act = 1'b0;
      SLCR_TPG_CHECKER: pat_word = phase_r ? `SLCR_CHECKER_B : `SLCR_CHECKER_A;
      SLCR_TPG_TOGGLE: pat_word = phase_r ? `SLCR_ZEROS : `SLCR_ONES;
      SLCR_TPG_PN_LONG: pat_word = pn_long_r[15:0];
      SLCR_TPG_PN_SHORT: pat_word = {pn_short_r[7:0], pn_short_r[8:1]};
      SLCR_TPG_USER_CONT: pat_word = user_word;
      SLCR_TPG_USER_ONCE: begin
        pat_word = user_word;
        pat_act = !user_done_r;
      end
      default: pat_act = 1'b0;
    endcase
  end

  // injection point and serial output conditioning
  wire inj_sample = link_cfg.inject_point == `SLCR_INJ_SAMPLE;
  wire inj_enc_out = link_cfg.inject_point == `SLCR_INJ_ENC_OUT;
  wire [15:0] data_sel = (pat_act && inj_sample) ? pat_word : sample_in;
  wire bypass = link_control_second_r[`SLCR_LC2_BYPASS_BIT];
  wire invert = link_control_second_r[`SLCR_LC2_INVERT_BIT];
  wire mirror = link_control_second_r[`SLCR_LC2_MIRROR_BIT];
  wire [9:0] sym_pre = (pat_act && inj_enc_out) ? pat_word[9:0] :
                       bypass ? enc_data_r[9:0] : enc_sym_in;
  logic [9:0] sym_rev;

  genvar g;
  generate
    for (g = 0; g < 10; g++) begin : g_mirror
      assign sym_rev[g] = sym_pre[9 - g];
    end
  endgenerate

  wire [9:0] sym_ordered = mirror ? sym_rev : sym_pre;
  wire [9:0] sym_final = invert ? ~sym_ordered : sym_ordered;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      enc_data_r <= 16'h0000;
      ser_sym_r <= 10'h000;
    end else begin
      enc_data_r <= data_sel;
      ser_sym_r <= sym_final;
    end
  end

  assign enc_data_out = enc_data_r;
  assign ser_sym_out = ser_sym_r;

endmodule // slcr_top

// >>> testbench/slcr_top_checker.sv
// checker: snoops serial-port writes, checks datapath outputs against the selected modes
// assumes bind onto slcr_top and serial bit-times of several sys_clk
`timescale 1ns/1ps
module slcr_top_checker
  import slcr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic spi_sclk,
  input wire logic spi_csb,
  input wire logic spi_sdio_i,
  input wire logic spi_sdio_o,
  input wire logic spi_sdio_oe,
  input wire logic [15:0] sample_in,
  input wire logic [9:0] enc_sym_in,
  input wire logic [15:0] selftest_signature,
  input wire logic [63:0] user_pattern_words,
  input wire logic link_sync_lvds_in,
  input wire logic link_sync_cmos_in,
  input wire logic [15:0] enc_data_out,
  input wire logic [9:0] ser_sym_out,
  input wire logic link_sync_request,
  input wire slcr_link_cfg_s link_cfg
);
  logic [2:0] sclk_r;
  logic [4:0] bit_r;
  logic [22:0] sh_r;
  logic [7:0] lc2_r;
  logic [7:0] lc3_r;
  logic [7:0] stab_r;
  wire rise = sclk_r[1] & ~sclk_r[2];
  wire [23:0] frm = {sh_r, spi_sdio_i};
  wire wr_hit = rise & ~spi_csb & (bit_r == 5'h17) & ~frm[23];
  wire [9:0] sym_rev = {<<{enc_sym_in}};
  wire [2:0] mode = lc3_r[2:0];
  // settled mode, no frame in flight
  wire ok = (stab_r > 8'h06) & spi_csb;
  wire plain = ok & (lc3_r[5:4] == 2'h0);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_r <= 3'h0;
      bit_r <= 5'h00;
      sh_r <= 23'h000000;
      lc2_r <= 8'h00;
      lc3_r <= 8'h00;
      stab_r <= 8'h00;
    end else begin
      sclk_r <= {sclk_r[1:0], spi_sclk};
      stab_r <= wr_hit ? 8'h00 : stab_r + {7'h00, stab_r != 8'hFF};
      bit_r <= spi_csb ? 5'h00 : bit_r + {4'h0, rise};
      if (rise) sh_r <= frm[22:0];
      if (wr_hit && frm[20:8] == 13'h0061) lc2_r <= frm[7:0];
      if (wr_hit && frm[20:8] == 13'h0062) lc3_r <= frm[7:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_normal;
    ok && (mode == 3'h0 || mode == 3'h7) |-> enc_data_out == $past(sample_in);
  endproperty
  a_normal: assert property (p_normal) else $error("sample word not passed");
  property p_checker;
    plain && mode == 3'h1 |-> (enc_data_out == 16'h5555 || enc_data_out == 16'hAAAA) && $changed(enc_data_out);
  endproperty
  a_checker: assert property (p_checker) else $error("checkerboard broken");
  property p_toggle;
    plain && mode == 3'h2 |=> $changed(enc_data_out) && (enc_data_out == 16'hFFFF || enc_data_out == 16'h0000);
  endproperty
  a_toggle: assert property (p_toggle) else $error("word toggle broken");
  property p_pn;
    plain && (mode == 3'h3 || mode == 3'h4) |-> enc_data_out != $past(enc_data_out);
  endproperty
  a_pn: assert property (p_pn) else $error("pseudo-random word stalled");
  property p_user;
    plain && mode == 3'h5 && enc_data_out == user_pattern_words[15:0] |=> enc_data_out == user_pattern_words[31:16]
      ##1 enc_data_out == user_pattern_words[47:32] ##1 enc_data_out == user_pattern_words[63:48];
  endproperty
  a_user: assert property (p_user) else $error("user word order broken");
  property p_once;
    plain && mode == 3'h6 && stab_r > 8'h10 |-> enc_data_out == $past(sample_in);
  endproperty
  a_once: assert property (p_once) else $error("user words repeated");
  property p_invert;
    plain && lc2_r[2:0] == 3'h2 |-> ser_sym_out == ~$past(enc_sym_in);
  endproperty
  a_invert: assert property (p_invert) else $error("symbol not inverted");
  property p_mirror;
    plain && lc2_r[2:0] == 3'h1 |-> ser_sym_out == $past(sym_rev);
  endproperty
  a_mirror: assert property (p_mirror) else $error("symbol not mirrored");
  property p_bypass;
    plain && lc2_r[2:0] == 3'h4 |-> ser_sym_out == $past(enc_data_out[9:0]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("encoder not bypassed");
  property p_sync_off;
    link_cfg.sync_mode == 2'h3 |=> !link_sync_request;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync request while pin off");
endmodule // slcr_top_checker

bind slcr_top slcr_top_checker slcr_top_checker_i (.sys_clk(sys_clk), .rst_b(rst_b), .spi_sclk(spi_sclk),
  .spi_csb(spi_csb), .spi_sdio_i(spi_sdio_i), .spi_sdio_o(spi_sdio_o), .spi_sdio_oe(spi_sdio_oe),
  .sample_in(sample_in), .enc_sym_in(enc_sym_in), .selftest_signature(selftest_signature),
  .user_pattern_words(user_pattern_words), .link_sync_lvds_in(link_sync_lvds_in),
  .link_sync_cmos_in(link_sync_cmos_in), .enc_data_out(enc_data_out), .ser_sym_out(ser_sym_out),
  .link_sync_request(link_sync_request), .link_cfg(link_cfg));

// >>> testbench/slcr_link_rx.sv
// downstream receiver model: raises its sync request on one pin buffer
// assumes level and buffer choice set by the bench; unused buffer carries the opposite level
`timescale 1ns/1ps
module slcr_link_rx (
  input wire logic sync_lvl,
  input wire logic sync_cmos_sel,
  output logic link_sync_lvds_in,
  output logic link_sync_cmos_in
);
  assign link_sync_lvds_in = sync_cmos_sel ? ~sync_lvl : sync_lvl;
  assign link_sync_cmos_in = sync_cmos_sel ? sync_lvl : ~sync_lvl;
endmodule // slcr_link_rx

// >>> testbench/slcr_top_test.sv
// bench: register access, pattern modes, output conditioning and sync selection
// assumes slcr_top, slcr_link_rx and the bound checker; inputs change at falling edges
`timescale 1ns/1ps
module slcr_top_test
  import slcr_pkg::*;
;
  localparam logic [15:0] SIG = 16'hA53C;
  localparam logic [63:0] UPW = 64'h9687B4A5D2C3F0E1;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic spi_sclk = 1'b0;
  logic spi_csb = 1'b1;
  logic tb_sdio = 1'b0;
  logic [15:0] cnt = 16'h0000;
  logic sync_lvl = 1'b0;
  logic sync_cmos_sel = 1'b0;
  logic lvds_w, cmos_w, sdio_o, sdio_oe, sync_req;
  logic [15:0] enc_out;
  logic [9:0] sym_out;
  slcr_link_cfg_s cfg;
  int err_count = 0;
  int num_checks = 0;
  int w0_hits = 0;
  wire sdio = sdio_oe ? sdio_o : tb_sdio;
  wire [9:0] sym_in = cnt[9:0] ^ 10'h2A7;
  always #12.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) cnt <= cnt + 16'h0001;
  always @(negedge sys_clk) if (enc_out === UPW[15:0]) w0_hits++;
  slcr_top slcr_top_i (.sys_clk(sys_clk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_csb(spi_csb),
    .spi_sdio_i(sdio), .spi_sdio_o(sdio_o), .spi_sdio_oe(sdio_oe), .sample_in(cnt), .enc_sym_in(sym_in),
    .selftest_signature(SIG), .user_pattern_words(UPW), .link_sync_lvds_in(lvds_w), .link_sync_cmos_in(cmos_w),
    .enc_data_out(enc_out), .ser_sym_out(sym_out), .link_sync_request(sync_req), .link_cfg(cfg));
  slcr_link_rx slcr_link_rx_i (.sync_lvl(sync_lvl), .sync_cmos_sel(sync_cmos_sel),
    .link_sync_lvds_in(lvds_w), .link_sync_cmos_in(cmos_w));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one frame: read flag, ignored length bits, address, data; msb first
  task automatic spi(input logic rd, input logic [12:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [23:0] f;
    f = {rd, 2'h0, a, d};
    q = 8'h00;
    @(negedge sys_clk) spi_csb = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      repeat (5) @(negedge sys_clk);
      spi_sclk = 1'b0;
      tb_sdio = f[i];
      repeat (5) @(negedge sys_clk);
      if (i < 8) q[i] = sdio;
      spi_sclk = 1'b1;
    end
    repeat (5) @(negedge sys_clk);
    spi_csb = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    spi(1'b0, a, d, q);
  endtask
  task automatic rdc(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] q;
    spi(1'b1, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, e});
  endtask
  function automatic logic [15:0] user_next(input logic [15:0] w);
    user_next = UPW[15:0];
    for (int j = 0; j < 3; j++)
      if (UPW[16*j +: 16] === w) user_next = UPW[16*j+16 +: 16];
  endfunction
  // short sequence x^9+x^5+1: state recovered from the word, 16 steps per word
  function automatic logic [15:0] pn9_next(input logic [15:0] w);
    logic [8:0] s;
    s = {w[7:0], w[8]};
    for (int j = 0; j < 16; j++)
      s = {s[7:0], s[8] ^ s[4]};
    pn9_next = {s[7:0], s[8:1]};
  endfunction
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    summarize();
  end
  initial begin
    logic [12:0] ra [9] = '{13'h0021, 13'h0024, 13'h0025, 13'h003A, 13'h0060, 13'h0061, 13'h0062, 13'h0063, 13'h0022};
    logic [7:0] rz [9] = '{8'h00, SIG[7:0], SIG[15:8], 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] rm [9] = '{8'h08, SIG[7:0], SIG[15:8], 8'h07, 8'h7F, 8'hF7, 8'hB7, 8'hFF, 8'h00};
    logic [7:0] sv [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'hC0, 8'h40};
    logic [5:0] se = 6'b100110;
    logic [15:0] prev, e;
    logic [9:0] r;
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    foreach (ra[i]) rdc(ra[i], rz[i]);
    foreach (ra[i]) begin
      wr(ra[i], 8'hFF);
      rdc(ra[i], rm[i]);
      if (i == 0) chk({15'h0000, cfg.pll_low_rate}, 16'h0001);
      if (i == 3) chk({13'h0000, cfg.div_next_sync_only, cfg.div_sync_en, cfg.master_sync_buf_en},
        16'h0007);
      if (i == 4) chk({9'h000, cfg.tail_bit_en, cfg.sample_en, cfg.link_sync_en, cfg.align_seq_mode,
        cfg.align_char_dis, cfg.link_pdwn}, 16'h007F);
      if (i == 5) chk({13'h0000, sync_req, cfg.sync_mode}, 16'h0003);
      if (i == 6) chk({13'h0000, cfg.chksum_dis, cfg.inject_point}, 16'h0007);
      if (i == 7) chk({8'h00, cfg.align_repeat}, 16'h00FF);
      wr(ra[i], 8'h00);
    end
    for (int c = 0; c < 8; c++) begin
      w0_hits = 0;
      wr(13'h0062, {5'h00, c[2:0]});
      repeat (20) @(negedge sys_clk);
      if (c == 5) chk({15'h0000, w0_hits > 2}, 16'h0001);
      else chk(w0_hits[15:0], (c == 6) ? 16'h0001 : 16'h0000);
      prev = enc_out;
      for (int k = 0; k < 6; k++) begin
        @(negedge sys_clk);
        case (c)
          1: e = (prev === 16'h5555) ? 16'hAAAA : 16'h5555;
          2: e = (prev === 16'hFFFF) ? 16'h0000 : 16'hFFFF;
          3: e = (enc_out === prev) ? ~prev : enc_out;
          4: e = pn9_next(prev);
          5: e = user_next(prev);
          default: e = cnt;
        endcase
        chk(enc_out, e);
        prev = enc_out;
      end
      wr(13'h0062, 8'h00);
    end
    wr(13'h0061, 8'h02);
    repeat (4) @(negedge sys_clk);
    chk({6'h00, sym_out}, {6'h00, ~sym_in});
    wr(13'h0061, 8'h01);
    repeat (4) @(negedge sys_clk);
    r = {<<{sym_in}};
    chk({6'h00, sym_out}, {6'h00, r});
    wr(13'h0061, 8'h04);
    repeat (4) @(negedge sys_clk);
    e = cnt - 16'h0001;
    chk({6'h00, sym_out}, {6'h00, e[9:0]});
    foreach (sv[i]) begin
      sync_lvl = i[0];
      sync_cmos_sel = sv[i][4];
      wr(13'h0061, sv[i]);
      repeat (4) @(negedge sys_clk);
      chk({15'h0000, sync_req}, {15'h0000, se[i]});
    end
    // checkerboard injected after the encoder: samples pass, symbols carry the pattern
    wr(13'h0062, 8'h11);
    @(negedge sys_clk);
    prev = {6'h00, sym_out};
    chk(enc_out, cnt);
    @(negedge sys_clk);
    chk({6'h00, sym_out}, (prev === 16'h0155) ? 16'h02AA : 16'h0155);
    summarize();
  end
endmodule // slcr_top_test
